// ==== rtl/ifm_defines.svh ====
`ifndef IFM_DEFINES_SVH
`define IFM_DEFINES_SVH

// Register byte offsets
`define IFM_CTRL_OFF 8'h00
`define IFM_SEL_OFF 8'h04
`define IFM_KEYS_OFF 8'h08
`define IFM_STAT_OFF 8'h0c
`define IFM_OUT_OFF 8'h10
`define IFM_MAPIDX_OFF 8'h14
`define IFM_MAPDAT_OFF 8'h18

// Selector values
`define IFM_SEL_TEACH 8'h62
`define IFM_SEL_TAUGHT 8'h63
`define IFM_SEL_SPEC_LO 8'h01
`define IFM_SEL_SPEC_HI 8'h07
`define IFM_SEL_RESET 8'h00

// Control bits (write-one pulses)
`define IFM_CTRL_DIR_BIT 0
`define IFM_CTRL_POWER_BIT 1

// Geometry
`define IFM_NUM_OUT 8
`define IFM_NUM_COMB 26
`define IFM_LAST_COMB 5'd25

// Power-loss abort time: 2000 ms
`define IFM_ABORT_MS 2000
`define IFM_CLK_MHZ 200

`endif

// ==== rtl/ifm_pkg.sv ====
package ifm_pkg;
    typedef enum logic [1:0] {IFM_IDLE, IFM_STEP, IFM_DONE} ifm_state_t;
    typedef logic [7:0] ifm_outs_t;
    typedef logic [4:0] ifm_comb_t;
endpackage

// ==== rtl/ifm_keysel.sv ====
`include "ifm_defines.svh"

// Builds the taught output set from key presses during a step
module ifm_keysel (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Control
    input wire logic clear,
    input wire logic key_press,
    input wire logic [3:0] key_num,
    // Result
    output ifm_pkg::ifm_outs_t sel
);
    import ifm_pkg::*;
    logic zero_toggle;

    // Key zero alternates between front and rear lights; keys one to six toggle output n+1
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sel <= 8'h00;
            zero_toggle <= 1'b0;
        end else if (clear) begin
            sel <= 8'h00;
            zero_toggle <= 1'b0;
        end else if (key_press) begin
            if (key_num == 4'h0) begin
                sel[0] <= ~zero_toggle;
                sel[1] <= zero_toggle;
                zero_toggle <= ~zero_toggle;
            end else if (key_num < 4'h7) begin
                sel[key_num[2:0] + 3'h1] <= ~sel[key_num[2:0] + 3'h1];
            end
        end
    end
endmodule

// ==== rtl/ifm_maptab.sv ====
`include "ifm_defines.svh"

// Stored taught map, one output set per key/direction combination
module ifm_maptab (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Write side
    input wire logic wr,
    input ifm_pkg::ifm_comb_t wr_idx,
    input ifm_pkg::ifm_outs_t wr_data,
    // Read sides
    input ifm_pkg::ifm_comb_t rd_idx,
    output ifm_pkg::ifm_outs_t rd_data,
    input ifm_pkg::ifm_comb_t sw_idx,
    output ifm_pkg::ifm_outs_t sw_data
);
    import ifm_pkg::*;
    ifm_outs_t mem [0:`IFM_NUM_COMB-1];

    // Contents survive selector changes; only a commit writes
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int i = 0; i < `IFM_NUM_COMB; i++) begin
                mem[i] <= 8'h00;
            end
        end else if (wr) begin
            mem[wr_idx] <= wr_data;
        end
    end

    // Registered read port for the output drive
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rd_data <= 8'h00;
        end else begin
            rd_data <= (rd_idx < 5'd26) ? mem[rd_idx] : 8'h00;
        end
    end

    // Bus read port is direct, so a read right after an index write sees the new entry
    assign sw_data = (sw_idx < 5'd26) ? mem[sw_idx] : 8'h00;
endmodule

// ==== rtl/ifm_top.sv ====
`include "ifm_defines.svh"

module ifm_top #(
    parameter int ABORT_CYCLES = `IFM_ABORT_MS * 1000 * `IFM_CLK_MHZ
) (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Function outputs, physical
    output logic [7:0] func_out,
    // Track power present, from pin
    input wire logic track_power
);
    import ifm_pkg::*;

    function automatic logic sel_is_special(input logic [7:0] v);
        return (v >= `IFM_SEL_SPEC_LO) && (v <= `IFM_SEL_SPEC_HI);
    endfunction

    // Bus address phase capture
    logic ph_wr;
    logic ph_rd;
    logic [7:0] ph_addr;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ph_wr <= 1'b0;
            ph_rd <= 1'b0;
            ph_addr <= 8'h00;
        end else if (hready) begin
            ph_wr <= hsel && htrans[1] && hwrite;
            ph_rd <= hsel && htrans[1] && !hwrite;
            ph_addr <= haddr[7:0];
        end
    end
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    // Power pin synchroniser
    logic pwr_s1;
    logic pwr_s2;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pwr_s1 <= 1'b1;
            pwr_s2 <= 1'b1;
        end else begin
            pwr_s1 <= track_power;
            pwr_s2 <= pwr_s1;
        end
    end

    // Decoded write strobes
    logic wr_sel;
    logic wr_ctrl;
    logic wr_keys;
    logic wr_mapidx;
    logic dir_cmd;
    assign wr_sel = ph_wr && ph_addr == `IFM_SEL_OFF;
    assign wr_ctrl = ph_wr && ph_addr == `IFM_CTRL_OFF;
    assign wr_keys = ph_wr && ph_addr == `IFM_KEYS_OFF;
    assign wr_mapidx = ph_wr && ph_addr == `IFM_MAPIDX_OFF;
    assign dir_cmd = wr_ctrl && hwdata[`IFM_CTRL_DIR_BIT];

    // Power-loss counter; aborts only after a sustained absence
    logic [31:0] off_cnt;
    logic pwr_abort;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            off_cnt <= 32'h0;
        end else if (pwr_s2) begin
            off_cnt <= 32'h0;
        end else if (off_cnt < 32'(ABORT_CYCLES)) begin
            off_cnt <= off_cnt + 32'h1;
        end
    end
    assign pwr_abort = (off_cnt == 32'(ABORT_CYCLES - 1));

    // Teaching sequencer
    ifm_state_t state;
    ifm_comb_t comb;
    logic [7:0] selector;
    logic [7:0] sel_saved;
    logic map_wr;
    ifm_outs_t step_sel;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state <= IFM_IDLE;
            comb <= 5'd0;
            selector <= `IFM_SEL_RESET;
            sel_saved <= `IFM_SEL_RESET;
        end else begin
            unique case (state)
                IFM_IDLE: begin
                    if (wr_sel) begin
                        selector <= hwdata[7:0];
                        if (hwdata[7:0] == `IFM_SEL_TEACH) begin
                            sel_saved <= selector;
                            state <= IFM_STEP;
                            comb <= 5'd0;
                        end
                    end
                end
                IFM_STEP: begin
                    if (pwr_abort) begin
                        // Selector from before entry comes back; stored map untouched
                        state <= IFM_IDLE;
                        selector <= sel_saved;
                    end else if (dir_cmd) begin
                        if (comb == `IFM_LAST_COMB) begin
                            state <= IFM_DONE;
                        end else begin
                            comb <= comb + 5'd1;
                        end
                    end
                end
                IFM_DONE: begin
                    if (pwr_abort) begin
                        state <= IFM_IDLE;
                        selector <= sel_saved;
                    end else if (dir_cmd) begin
                        state <= IFM_IDLE;
                        selector <= `IFM_SEL_TAUGHT;
                    end
                end
            endcase
        end
    end

    // Staging: partial teaching commits only on final confirm
    ifm_outs_t stage [0:`IFM_NUM_COMB-1];
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int i = 0; i < `IFM_NUM_COMB; i++) begin
                stage[i] <= 8'h00;
            end
        end else if (state == IFM_STEP && dir_cmd) begin
            stage[comb] <= step_sel;
        end
    end

    // Copy stage to stored map after final confirm
    logic commit;
    ifm_comb_t cp_idx;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            commit <= 1'b0;
            cp_idx <= 5'd0;
        end else if (state == IFM_DONE && dir_cmd && !pwr_abort) begin
            commit <= 1'b1;
            cp_idx <= 5'd0;
        end else if (commit) begin
            commit <= (cp_idx != `IFM_LAST_COMB);
            cp_idx <= cp_idx + 5'd1;
        end
    end
    assign map_wr = commit;

    // Key inputs: low 13 bits are key levels, bit 15 = forward direction
    logic [12:0] keys;
    logic fwd;
    logic [12:0] keys_prev;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            keys <= 13'h0;
            fwd <= 1'b1;
        end else if (wr_keys) begin
            keys <= hwdata[12:0];
            fwd <= hwdata[15];
        end
    end

    // One key press per cycle, lowest changed key first
    logic key_press;
    logic [3:0] key_num;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            keys_prev <= 13'h0;
        end else if (!key_press || state != IFM_STEP) begin
            keys_prev <= keys;
        end else begin
            keys_prev[key_num] <= keys[key_num];
        end
    end
    always_comb begin
        key_press = 1'b0;
        key_num = 4'h0;
        for (int k = 12; k >= 0; k--) begin
            if (keys[k] != keys_prev[k]) begin
                key_press = (state == IFM_STEP);
                key_num = 4'(k);
            end
        end
    end

    ifm_keysel u_keysel (
        .hclk(hclk),
        .hresetn(hresetn),
        .clear(state != IFM_STEP || dir_cmd),
        .key_press(key_press),
        .key_num(key_num),
        .sel(step_sel)
    );

    // Current key/direction index used for driving in normal mode
    ifm_comb_t run_idx;
    logic [4:0] sw_idx;
    ifm_outs_t run_map;
    ifm_outs_t sw_data;
    always_comb begin
        run_idx = 5'd0;
        for (int k = 0; k < 13; k++) begin
            if (keys[k]) begin
                run_idx = 5'((k * 2) + (fwd ? 0 : 1));
            end
        end
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sw_idx <= 5'd0;
        end else if (wr_mapidx) begin
            sw_idx <= hwdata[4:0];
        end
    end

    ifm_maptab u_maptab (
        .hclk(hclk),
        .hresetn(hresetn),
        .wr(map_wr),
        .wr_idx(cp_idx),
        .wr_data(stage[cp_idx]),
        .rd_idx(run_idx),
        .rd_data(run_map),
        .sw_idx(sw_idx),
        .sw_data(sw_data)
    );

    // Standard per-key mapping: keys one to six drive output n+1, key zero by direction
    function automatic ifm_outs_t std_map(input logic [12:0] k, input logic f);
        ifm_outs_t o;
        o = 8'h00;
        o[0] = k[0] && f;
        o[1] = k[0] && !f;
        for (int i = 1; i < 7; i++) begin
            o[i + 1] = k[i];
        end
        return o;
    endfunction

    // Output drive; outputs are physical, effects never remapped
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            func_out <= 8'h00;
        end else if (state == IFM_STEP) begin
            func_out <= step_sel;
        end else if (state == IFM_DONE) begin
            func_out <= 8'h03;
        end else if (selector == `IFM_SEL_TAUGHT) begin
            func_out <= (keys != 13'h0) ? run_map : 8'h00;
        end else if (sel_is_special(selector)) begin
            func_out <= std_map(keys, fwd) & 8'h0f;
        end else begin
            func_out <= std_map(keys, fwd);
        end
    end

    // Read mux
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0;
        end else if (hready && hsel && htrans[1] && !hwrite) begin
            unique case (haddr[7:0])
                `IFM_SEL_OFF: hrdata <= {24'h0, selector};
                `IFM_KEYS_OFF: hrdata <= {16'h0, fwd, 2'b00, keys};
                `IFM_STAT_OFF: hrdata <= {22'h0, 5'(comb), 3'(state), pwr_s2, 1'b0};
                `IFM_OUT_OFF: hrdata <= {24'h0, func_out};
                `IFM_MAPIDX_OFF: hrdata <= {27'h0, sw_idx};
                `IFM_MAPDAT_OFF: hrdata <= {24'h0, sw_data};
                default: hrdata <= 32'h0;
            endcase
        end
    end

    // Checks
    sequence s_last_confirm;
        state == IFM_STEP && comb == `IFM_LAST_COMB && dir_cmd && !pwr_abort;
    endsequence
    chk_teach_entry: assert property (@(posedge hclk) disable iff (!hresetn)
        state == IFM_IDLE && wr_sel && hwdata[7:0] == 8'h62 |=> state == IFM_STEP && comb == 0)
        else $error("teach not entered");
    chk_step_advance: assert property (@(posedge hclk) disable iff (!hresetn)
        state == IFM_STEP && dir_cmd && !pwr_abort && comb < 25 |=> comb == $past(comb) + 1)
        else $error("step not advanced");
    chk_last_done: assert property (@(posedge hclk) disable iff (!hresetn)
        s_last_confirm |=> state == IFM_DONE ##1 func_out == 8'h03)
        else $error("end indication missing");
    chk_final_sel: assert property (@(posedge hclk) disable iff (!hresetn)
        state == IFM_DONE && dir_cmd && !pwr_abort |=> selector == 8'h63 && state == IFM_IDLE)
        else $error("selector not 99");
    chk_abort_keep: assert property (@(posedge hclk) disable iff (!hresetn)
        state != IFM_IDLE && pwr_abort |=> state == IFM_IDLE && selector == $past(sel_saved) && !commit)
        else $error("abort wrong");
    chk_step_hold: assert property (@(posedge hclk) disable iff (!hresetn)
        state == IFM_STEP && !dir_cmd && !pwr_abort |=> state == IFM_STEP && $stable(comb))
        else $error("left step early");
    chk_first_comb: assert property (@(posedge hclk) disable iff (!hresetn)
        $rose(state == IFM_STEP) |-> comb == 0)
        else $error("first step not key zero");
    chk_disable_sel: assert property (@(posedge hclk) disable iff (!hresetn)
        state == IFM_IDLE && wr_sel && hwdata[7:0] < 8'h62 |=> selector != 8'h63)
        else $error("map not disabled");
endmodule

// ==== test/ifm_cab_model.sv ====
`include "ifm_defines.svh"

// Command station and cab: bus master for the decoder's registers and the track supply
module ifm_cab_model (
    // Clock and bus answer
    input wire logic hclk,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    // Bus request
    output logic hsel,
    output logic [31:0] haddr,
    output logic [1:0] htrans,
    output logic hwrite,
    output logic [2:0] hsize,
    output logic [31:0] hwdata,
    // Track supply
    output logic track_power
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [31:0] rd_val = 32'h0;
    int rd_cnt = 0;

    // Idle bus and powered track from time zero
    initial begin
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'b010;
        hwdata = 32'h0;
        track_power = 1'b1;
    end

    // One single word transfer; waits as long as the slave holds ready low
    task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= wr;
        htrans <= 2'b10;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        htrans <= 2'b00;
        hsel <= 1'b0;
        // On reads the data lines carry junk so a stale value is never mistaken for data
        hwdata <= wr ? d : ~hwdata;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        if (!wr) begin
            rd_val = hrdata;
            rd_cnt++;
        end
    endtask

    task automatic write(input logic [31:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask

    task automatic read(input logic [31:0] a);
        xfer(1'b0, a, 32'h0);
    endtask

    // Loco forward with every function off before teaching starts
    task automatic prepare();
        write({24'h0, `IFM_KEYS_OFF}, 32'h0000_8000);
    endtask

    // Direction key pressed to confirm a step
    task automatic confirm();
        write({24'h0, `IFM_CTRL_OFF}, 32'h1);
    endtask

    // Loco lifted off the track for n cycles
    task automatic power_gap(input int n);
        track_power <= 1'b0;
        repeat (n) @(posedge hclk);
        track_power <= 1'b1;
    endtask
endmodule

// ==== test/interactive_function_mapping_test.sv ====
`include "ifm_defines.svh"

module interactive_function_mapping_test;
    timeunit 1ns;
    timeprecision 1ps;
    import ifm_pkg::*;

    // Short abort time keeps the power-loss case cheap
    localparam int ABORT = 50;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel;
    logic hwrite;
    logic [31:0] haddr;
    logic [31:0] hwdata;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic track_power;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic [7:0] func_out;
    int failures = 0;
    int n_tests = 0;
    int pin_evt = 0;
    logic [31:0] q_rd[$];
    logic [31:0] q_msk[$];
    ifm_outs_t q_pin[$];
    ifm_outs_t taught[26];
    logic [12:0] keys = 13'h0;

    always #2.5 hclk = ~hclk;

    ifm_top #(.ABORT_CYCLES(ABORT)) DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .func_out(func_out), .track_power(track_power));

    ifm_cab_model cab (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .track_power(track_power));

    task automatic cmp_rd(input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] t=%0t bus exp=%h got=%h", $time, exp, got);
        end
    endtask

    task automatic cmp_pin(input ifm_outs_t exp, input ifm_outs_t got);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] t=%0t outputs exp=%h got=%h", $time, exp, got);
        end
    endtask

    // Result watchers take the oldest note whenever a read or an output sample lands
    always @(cab.rd_cnt) begin
        cmp_rd(q_rd.pop_front(), cab.rd_val & q_msk.pop_front());
        cmp_rd(32'h2, {30'h0, hreadyout, hresp});
    end

    always @(pin_evt) begin
        cmp_pin(q_pin.pop_front(), func_out);
    end

    task automatic expect_rd(input logic [7:0] off, input logic [31:0] exp,
                             input logic [31:0] msk = 32'hffff_ffff);
        q_rd.push_back(exp & msk);
        q_msk.push_back(msk);
        cab.read({24'h0, off});
    endtask

    // Up to six key changes are taken one per cycle, then two register stages follow
    task automatic expect_pin(input ifm_outs_t exp);
        repeat (12) @(posedge hclk);
        q_pin.push_back(exp);
        pin_evt++;
    endtask

    task automatic wr(input logic [7:0] off, input logic [31:0] d);
        cab.write({24'h0, off}, d);
    endtask

    task automatic set_keys(input logic [12:0] k, input logic fwd);
        keys = k;
        wr(`IFM_KEYS_OFF, {16'h0, fwd, 2'b00, k});
    endtask

    // Status word with track power present: index, state, power flag
    function automatic logic [31:0] st(input logic [2:0] s, input logic [4:0] c);
        return {22'h0, c, s, 2'b10};
    endfunction

    task automatic print_verdict();
        if (failures == 0 && n_tests > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // Whole run is about a thousand cycles; this only catches a hung handshake
    initial begin
        repeat (20000) @(posedge hclk);
        failures++;
        print_verdict();
    end

    initial begin
        logic [5:0] m;
        void'($urandom(32'h0c5b));
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        expect_rd(`IFM_SEL_OFF, 32'h0);
        expect_rd(8'h1c, 32'h0);
        expect_pin(8'h00);
        cab.prepare();
        wr(`IFM_SEL_OFF, {24'h0, `IFM_SEL_TEACH});
        expect_rd(`IFM_STAT_OFF, st(3'd1, 5'd0));
        wr(`IFM_SEL_OFF, 32'h5);
        expect_rd(`IFM_SEL_OFF, {24'h0, `IFM_SEL_TEACH});
        // Key zero pressed twice within the first step
        set_keys(13'h1, 1'b1);
        expect_pin(8'h01);
        set_keys(13'h0, 1'b1);
        expect_pin(8'h02);
        for (int c = 0; c < 26; c++) begin
            m = 6'($urandom());
            set_keys(keys ^ {6'h0, m, 1'b0}, 1'b1);
            taught[c] = {m, 2'b00} | ((c == 0) ? 8'h02 : 8'h00);
            expect_pin(taught[c]);
            cab.confirm();
            if (c < 25) begin
                expect_rd(`IFM_STAT_OFF, st(3'd1, 5'(c + 1)));
            end
        end
        expect_pin(8'h03);
        expect_rd(`IFM_STAT_OFF, st(3'd2, 5'd0), 32'h1c);
        cab.confirm();
        repeat (40) @(posedge hclk);
        expect_rd(`IFM_SEL_OFF, {24'h0, `IFM_SEL_TAUGHT});
        expect_rd(`IFM_STAT_OFF, st(3'd0, 5'd0), 32'h1c);
        for (int c = 0; c < 26; c++) begin
            wr(`IFM_MAPIDX_OFF, 32'(c));
            expect_rd(`IFM_MAPDAT_OFF, {24'h0, taught[c]});
        end
        // Taught map drives outputs from key one in both directions
        set_keys(13'h2, 1'b1);
        expect_pin(taught[2]);
        set_keys(13'h2, 1'b0);
        expect_pin(taught[3]);
        wr(`IFM_SEL_OFF, 32'h20);
        expect_rd(`IFM_SEL_OFF, 32'h20);
        expect_pin(8'h04);
        for (int s = 1; s <= 7; s++) begin
            wr(`IFM_SEL_OFF, 32'(s));
            expect_rd(`IFM_SEL_OFF, 32'(s));
            expect_pin(8'h04);
        end
        // Key three reaches output four only in the standard table
        set_keys(13'h0a, 1'b0);
        expect_pin(8'h04);
        wr(`IFM_SEL_OFF, 32'h20);
        expect_pin(8'h14);
        set_keys(13'h2, 1'b0);
        expect_rd(`IFM_MAPDAT_OFF, {24'h0, taught[25]});
        wr(`IFM_SEL_OFF, {24'h0, `IFM_SEL_TAUGHT});
        expect_pin(taught[3]);
        // Start again, then lose power part way through
        set_keys(13'h0, 1'b1);
        wr(`IFM_SEL_OFF, {24'h0, `IFM_SEL_TEACH});
        set_keys(13'h4, 1'b1);
        expect_pin(8'h08);
        cab.confirm();
        cab.power_gap(ABORT - 30);
        repeat (5) @(posedge hclk);
        expect_rd(`IFM_STAT_OFF, st(3'd1, 5'd1));
        cab.power_gap(ABORT + 20);
        repeat (5) @(posedge hclk);
        expect_rd(`IFM_STAT_OFF, st(3'd0, 5'd0), 32'h1c);
        expect_rd(`IFM_SEL_OFF, {24'h0, `IFM_SEL_TAUGHT});
        wr(`IFM_MAPIDX_OFF, 32'h0);
        expect_rd(`IFM_MAPDAT_OFF, {24'h0, taught[0]});
        repeat (5) @(posedge hclk);
        print_verdict();
    end
endmodule
